// ===== verilog/sadc_defs.svh
// Register map, field positions and reset values of the secondary converter setup block
// Functional notes
// [RULE1] The channel select register holds a 3-bit channel address in its low bits and reads zero above.
// [RULE2] A clear pair bit makes address n pick pin n alone; a set pair bit makes even/odd addresses a +/- or -/+ pair.
// [RULE3] The SAR clock is the system clock divided by the 5-bit divider field plus one, held in bits 7 to 3.
// [RULE4] The 2-bit gain field in bits 1 to 0 selects gain 0.5, 1, 2 or 4, and bit 2 reads zero.
// [RULE5] Reset loads the configuration register with all ones in the divider and zeros below it.
// [RULE6] Results are two's complement for a differential channel and unsigned for a single-ended one.
// [RULE7] Mux and gain controls follow the registers so that a write acts from the next clock edge.
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define SADC_ADDR_PAIR_CFG  8'hBA
`define SADC_ADDR_CHAN_SEL  8'hBB
`define SADC_ADDR_CONV_CFG  8'hBC

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define SADC_DIV_W          5
`define SADC_DIV_MSB        7
`define SADC_DIV_LSB        3
`define SADC_GAIN_MSB       1
`define SADC_GAIN_LSB       0
`define SADC_CHAN_MSB       2
`define SADC_PAIR_MSB       3

// ****************************************************************
// Reset values
// ****************************************************************
`define SADC_RST_CONV_CFG   8'hF8
`define SADC_RST_CHAN_SEL   8'h00
`define SADC_RST_PAIR_CFG   8'h00

`endif

// ===== verilog/sadc_pkg.sv
// Types and mux decode shared by the converter setup block
`default_nettype none
package sadc_pkg;

    typedef enum logic [1:0] {
        SADC_GAIN_HALF,
        SADC_GAIN_ONE,
        SADC_GAIN_TWO,
        SADC_GAIN_FOUR
    } sadc_gain_t;

    typedef struct packed {
        logic       diff;
        logic [2:0] pos;
        logic [2:0] neg;
    } sadc_mux_t;

    // Neg is meaningless for a single-ended pick and is parked on pin 0
    function automatic sadc_mux_t sadc_mux_decode(input logic [2:0] chan,
                                                  input logic [3:0] pair);
        sadc_mux_t m;
        m.diff = pair[chan[2:1]];
        if (m.diff) begin
            m.pos = {chan[2:1], chan[0]};
            m.neg = {chan[2:1], ~chan[0]};
        end else begin
            m.pos = chan;
            m.neg = 3'h0;
        end
        return m;
    endfunction

endpackage
`default_nettype wire

// ===== verilog/sadc_clkdiv.sv
// SAR clock divider with programmable ratio
`include "sadc_defs.svh"
`default_nettype none
module sadc_clkdiv #(
    parameter int WIDTH = `SADC_DIV_W
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    // Ratio minus one
    input  wire logic [WIDTH-1:0] div,
    // SAR clock
    output logic                  sar_clk,
    output logic                  sar_tick
);

    if (WIDTH < 1) begin : g_width_chk
        $error("sadc_clkdiv: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic             wrap;

    // Compare with >= so a smaller ratio written mid-period cannot strand the count
    assign wrap  = (cnt_q >= div);
    assign cnt_d = wrap ? '0 : cnt_q + 1'b1;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_d; // [RULE3]
        end
    end

    // High for the first half of each period, rounded up; ratio 1 stays high
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sar_clk  <= 1'b0;
            sar_tick <= 1'b0;
        end else if (clk_en) begin
            sar_clk  <= (cnt_d <= (div >> 1));
            sar_tick <= wrap; // [RULE3]
        end
    end

    // ****************************************************************
    // Checking
    // ****************************************************************
    logic [WIDTH:0]   gap_q;
    logic [WIDTH-1:0] div_prev_q;
    logic             stable_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            gap_q      <= '0;
            div_prev_q <= '0;
            stable_q   <= 1'b0;
        end else if (clk_en) begin
            gap_q      <= sar_tick ? '0 : gap_q + 1'b1;
            div_prev_q <= div;
            if (div != div_prev_q) begin
                stable_q <= 1'b0;
            end else if (sar_tick) begin
                stable_q <= 1'b1;
            end
        end
    end

    sar_period_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RULE3]
        clk_en && sar_tick && stable_q && (div == div_prev_q) |-> gap_q == {1'b0, div})
        else $error("SAR tick spacing differs from divider plus one");

endmodule
`default_nettype wire

// ===== verilog/sadc_top.sv
// Input mux, SAR clock and amplifier gain setup of the secondary converter
`include "sadc_defs.svh"
`default_nettype none
module sadc_top
    import sadc_pkg::*;
#(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // Special-function register port
    input  wire logic [7:0]        sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic [7:0]        sfr_wdata,
    input  wire logic              sfr_rd,
    output logic      [7:0]        sfr_rdata,
    // Mux and amplifier controls
    output logic      [2:0]        mux_pos_sel,
    output logic      [2:0]        mux_neg_sel,
    output logic                   mux_diff,
    output logic      [1:0]        gain_sel,
    // SAR clock
    output logic                   sar_clk,
    output logic                   sar_tick,
    // Conversion result
    input  wire logic              conv_valid,
    input  wire logic [DATA_W-1:0] conv_raw,
    output logic                   result_valid,
    output logic      [DATA_W-1:0] result_data,
    output logic                   result_signed
);

    if (DATA_W < 2) begin : g_width_chk
        $error("sadc_top: DATA_W must be at least 2");
    end

    // ****************************************************************
    // Reset images
    // ****************************************************************
    // Held as parameters because a macro literal cannot be bit-selected
    localparam logic [7:0] RST_CONV = `SADC_RST_CONV_CFG;
    localparam logic [7:0] RST_CHAN = `SADC_RST_CHAN_SEL;
    localparam logic [7:0] RST_PAIR = `SADC_RST_PAIR_CFG;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [`SADC_DIV_W-1:0] div_q;
    logic [`SADC_DIV_W-1:0] div_d;
    sadc_gain_t             gain_q;
    sadc_gain_t             gain_d;
    logic [2:0]             chan_q;
    logic [2:0]             chan_d;
    logic [3:0]             pair_q;
    logic [3:0]             pair_d;
    logic                   wr_conv;
    logic                   wr_chan;
    logic                   wr_pair;
    sadc_mux_t              mux_d;

    assign wr_conv = clk_en && sfr_wr && (sfr_addr == `SADC_ADDR_CONV_CFG);
    assign wr_chan = clk_en && sfr_wr && (sfr_addr == `SADC_ADDR_CHAN_SEL);
    assign wr_pair = clk_en && sfr_wr && (sfr_addr == `SADC_ADDR_PAIR_CFG);

    always_comb begin
        div_d  = div_q;
        gain_d = gain_q;
        chan_d = chan_q;
        pair_d = pair_q;
        if (wr_conv) begin
            div_d  = sfr_wdata[`SADC_DIV_MSB:`SADC_DIV_LSB]; // [RULE3]
            gain_d = sadc_gain_t'(sfr_wdata[`SADC_GAIN_MSB:`SADC_GAIN_LSB]); // [RULE4]
        end
        if (wr_chan) begin
            chan_d = sfr_wdata[`SADC_CHAN_MSB:0]; // [RULE1]
        end
        if (wr_pair) begin
            pair_d = sfr_wdata[`SADC_PAIR_MSB:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            div_q  <= RST_CONV[`SADC_DIV_MSB:`SADC_DIV_LSB]; // [RULE5]
            gain_q <= sadc_gain_t'(RST_CONV[`SADC_GAIN_MSB:`SADC_GAIN_LSB]); // [RULE5]
            chan_q <= RST_CHAN[`SADC_CHAN_MSB:0];
            pair_q <= RST_PAIR[`SADC_PAIR_MSB:0];
        end else if (clk_en) begin
            div_q  <= div_d;
            gain_q <= gain_d;
            chan_q <= chan_d;
            pair_q <= pair_d;
        end
    end

    // ****************************************************************
    // Read-back
    // ****************************************************************
    // Unmapped addresses read zero; data stands until the next read
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sfr_rdata <= 8'h00;
        end else if (clk_en && sfr_rd) begin
            case (sfr_addr)
                `SADC_ADDR_CONV_CFG: sfr_rdata <= {div_q, 1'b0, gain_q}; // [RULE4]
                `SADC_ADDR_CHAN_SEL: sfr_rdata <= {5'h00, chan_q}; // [RULE1]
                `SADC_ADDR_PAIR_CFG: sfr_rdata <= {4'h0, pair_q};
                default:             sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Mux and gain controls
    // ****************************************************************
    // Decoded from next-state values so outputs move on the same edge as the register
    assign mux_d = sadc_mux_decode(chan_d, pair_d); // [RULE2]

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mux_diff    <= 1'b0;
            mux_pos_sel <= 3'h0;
            mux_neg_sel <= 3'h0;
            gain_sel    <= RST_CONV[`SADC_GAIN_MSB:`SADC_GAIN_LSB]; // [RULE5]
        end else if (clk_en) begin
            mux_diff    <= mux_d.diff; // [RULE7]
            mux_pos_sel <= mux_d.pos; // [RULE2]
            mux_neg_sel <= mux_d.neg; // [RULE2]
            gain_sel    <= gain_d; // [RULE7]
        end
    end

    // ****************************************************************
    // SAR clock
    // ****************************************************************
    sadc_clkdiv #(
        .WIDTH    (`SADC_DIV_W)
    ) u_clkdiv (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .div      (div_q),
        .sar_clk  (sar_clk),
        .sar_tick (sar_tick)
    );

    // ****************************************************************
    // Result formatting
    // ****************************************************************
    // Raw SAR code is offset binary; flipping the top bit gives two's complement
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            result_valid  <= 1'b0;
            result_data   <= '0;
            result_signed <= 1'b0;
        end else if (clk_en) begin
            result_valid <= conv_valid;
            if (conv_valid) begin
                result_signed <= mux_diff; // [RULE6]
                if (mux_diff) begin
                    result_data <= {~conv_raw[DATA_W-1], conv_raw[DATA_W-2:0]}; // [RULE6]
                end else begin
                    result_data <= conv_raw;
                end
            end
        end
    end

    // ****************************************************************
    // Checking
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence conv_cfg_write;
        clk_en && sfr_wr && (sfr_addr == `SADC_ADDR_CONV_CFG);
    endsequence

    sequence chan_read;
        clk_en && sfr_rd && (sfr_addr == `SADC_ADDR_CHAN_SEL);
    endsequence

    sequence conv_read;
        clk_en && sfr_rd && (sfr_addr == `SADC_ADDR_CONV_CFG);
    endsequence

    chan_readback_a: assert property ( // [RULE1]
        chan_read |=> sfr_rdata == {5'h00, $past(chan_q)})
        else $error("Channel select read-back wrong or upper bits set");

    mux_pairing_a: assert property ( // [RULE2]
        (mux_diff == pair_q[chan_q[2:1]]) &&
        (mux_diff ? (mux_pos_sel == {chan_q[2:1], chan_q[0]}) &&
                    (mux_neg_sel == {chan_q[2:1], ~chan_q[0]})
                  : (mux_pos_sel == chan_q)))
        else $error("Mux selection does not match address and pair bits");

    gain_readback_a: assert property ( // [RULE4]
        conv_read |=> (sfr_rdata[2] == 1'b0) && (sfr_rdata[1:0] == $past(gain_q)) &&
                      (sfr_rdata[7:3] == $past(div_q)))
        else $error("Configuration read-back wrong or bit 2 set");

    reset_config_a: assert property (disable iff (1'b0) // [RULE5]
        !rst_b |=> ({div_q, 1'b0, gain_q} == `SADC_RST_CONV_CFG) && (gain_sel == 2'h0))
        else $error("Configuration not at reset value after reset");

    result_format_a: assert property ( // [RULE6]
        clk_en && conv_valid |=> result_valid && (result_signed == $past(mux_diff)) &&
        (result_data[DATA_W-1] == ($past(conv_raw[DATA_W-1]) ^ $past(mux_diff))))
        else $error("Result format does not follow channel mode");

    write_effect_a: assert property ( // [RULE7]
        conv_cfg_write |=> (gain_sel == $past(sfr_wdata[1:0])) &&
                           (div_q == $past(sfr_wdata[7:3])))
        else $error("Gain control did not follow configuration write");

    freeze_hold_a: assert property ( // [RULE7]
        !clk_en |=> $stable(gain_sel) && $stable(mux_pos_sel) && $stable(mux_diff))
        else $error("Controls moved while clock enable was low");

endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench of the secondary converter setup block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic       mclk, rst_b, clk_en, sfr_wr, sfr_rd, conv_valid;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, conv_raw, result_data;
    logic [2:0] mux_pos_sel, mux_neg_sel;
    logic [1:0] gain_sel;
    logic       mux_diff, sar_clk, sar_tick, result_valid, result_signed;
    int         miscompares, check_count, cycles, n;

    sadc_top #(.DATA_W(8)) i_sadc_top (
        .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel),
        .mux_diff(mux_diff), .gain_sel(gain_sel),
        .sar_clk(sar_clk), .sar_tick(sar_tick),
        .conv_valid(conv_valid), .conv_raw(conv_raw), .result_valid(result_valid),
        .result_data(result_data), .result_signed(result_signed)
    );

    // ****************************************************************
    // Clock, watchdog and reporting
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Ceiling far above the roughly 800 cycles the scenarios need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // ****************************************************************
    // Register port cycles, driven on the falling edge
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check(8'(gain_sel), 8'h00, "gain after reset");
        check(8'(mux_diff), 8'h00, "diff after reset");
        rd(8'hBC);
        check(sfr_rdata, 8'hF8, "config reset");
        rd(8'hBB);
        check(sfr_rdata, 8'h00, "channel reset");
    endtask

    task automatic t_regs();
        wr(8'hBB, 8'hFF);
        rd(8'hBB);
        check(sfr_rdata, 8'h07, "channel upper bits");
        wr(8'hBC, 8'hFF);
        rd(8'hBC);
        check(sfr_rdata, 8'hFB, "config bit 2");
        wr(8'h55, 8'hAA);
        rd(8'h55);
        check(sfr_rdata, 8'h00, "unmapped read");
        // Write while frozen must be lost
        clk_en = 1'b0;
        wr(8'hBC, 8'h00);
        clk_en = 1'b1;
        rd(8'hBC);
        check(sfr_rdata, 8'hFB, "frozen write");
    endtask

    task automatic t_mux();
        logic [3:0] p;
        logic [2:0] c;
        logic       d;
        for (int i = 0; i < 128; i++) begin
            p = 4'(i >> 3);
            c = 3'(i);
            d = p[c[2:1]];
            wr(8'hBA, {4'h0, p});
            wr(8'hBB, {5'h00, c});
            check(8'(mux_diff), 8'(d), "pair mode");
            check(8'(mux_pos_sel), 8'(c), "positive pin");
            if (d) begin
                check(8'(mux_neg_sel), 8'(c ^ 3'h1), "negative pin");
            end
        end
    endtask

    task automatic t_gain();
        for (int g = 0; g < 4; g++) begin
            wr(8'hBC, 8'(8'h10 | g));
            check(8'(gain_sel), 8'(g), "gain code");
            rd(8'hBC);
            check(sfr_rdata, 8'(8'h10 | g), "gain readback");
        end
    endtask

    task automatic t_div();
        int divs[4] = '{0, 1, 3, 31};
        int hi_cnt;
        foreach (divs[k]) begin
            wr(8'hBC, 8'(divs[k] << 3));
            repeat (40) @(negedge mclk);
            n = 0;
            while (!sar_tick && n < 100) begin
                @(negedge mclk);
                n++;
            end
            n = 0;
            hi_cnt = 0;
            // One full period sampled: high for the first ceil(N/2) of N cycles
            do begin
                @(negedge mclk);
                n++;
                hi_cnt += int'(sar_clk);
            end while (!sar_tick && n < 100);
            check(8'(n), 8'(divs[k] + 1), "tick spacing");
            check(8'(hi_cnt), 8'((divs[k] + 2) / 2), "sar clock high time");
        end
    endtask

    task automatic conv(input logic [7:0] raw, input logic [7:0] exp, input logic sgn);
        @(negedge mclk);
        conv_raw   = raw;
        conv_valid = 1'b1;
        @(negedge mclk);
        conv_valid = 1'b0;
        check(8'(result_valid), 8'h01, "result valid");
        check(result_data, exp, "result data");
        check(8'(result_signed), 8'(sgn), "result format");
    endtask

    task automatic t_result();
        wr(8'hBA, 8'h01);
        wr(8'hBB, 8'h01);
        conv(8'h80, 8'h00, 1'b1);
        conv(8'h3C, 8'hBC, 1'b1);
        wr(8'hBB, 8'h02);
        conv(8'h80, 8'h80, 1'b0);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_b       = 1'b0;
        clk_en      = 1'b1;
        sfr_wr      = 1'b0;
        sfr_rd      = 1'b0;
        sfr_addr    = 8'h00;
        sfr_wdata   = 8'h00;
        conv_valid  = 1'b0;
        conv_raw    = 8'h00;
        miscompares = 0;
        check_count = 0;
        cycles      = 0;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        t_reset();
        t_regs();
        t_mux();
        t_gain();
        t_div();
        t_result();
        results();
    end
endmodule
`default_nettype wire
